// >>> logic/icr_pkg.sv
/*
  Package of the ingress credit threshold register bank: offsets, field
  layout, reset defaults, masks, states and small timing counts.
  Assumes a single core clock domain; used through icr_pkg:: only.
*/
package icr_pkg;

  // ----------------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------------
  localparam int NUM_GRP = 7; // st0: 2 groups, st1: 3 groups, st2: 2 groups
  localparam int CRED_W = 10;
  localparam int OFF_W = 12;
  localparam logic [2:0] STN_BASE_0 = 3'h0;
  localparam logic [2:0] STN_BASE_1 = 3'h2;
  localparam logic [2:0] STN_BASE_2 = 3'h5;
  localparam logic [1:0] STN_0 = 2'h0;
  localparam logic [1:0] STN_1 = 2'h1;
  localparam logic [1:0] STN_2 = 2'h2;
  localparam int GRP_INTERNAL = 2; // station 1 first slot, no external link

  // ----------------------------------------------------------------------
  // register offsets and word selects
  // ----------------------------------------------------------------------
  localparam logic [11:0] OFF_POSTED_FIRST = 12'hA00;
  localparam logic [11:0] OFF_NONPOSTED_FIRST = 12'hA04;
  localparam logic [11:0] OFF_COMPLETION_FIRST = 12'hA08;
  localparam logic [11:0] OFF_POSTED_SECOND = 12'hA18;
  localparam logic [11:0] OFF_NONPOSTED_SECOND = 12'hA1C;
  localparam logic [11:0] OFF_COMPLETION_SECOND = 12'hA20;
  localparam logic [11:0] OFF_POSTED_SIXTH = 12'hA30;
  localparam logic [11:0] OFF_NONPOSTED_SIXTH = 12'hA34;
  localparam logic [11:0] OFF_COMPLETION_SIXTH = 12'hA38;
  localparam logic [1:0] SEL_P = 2'h0;
  localparam logic [1:0] SEL_NP = 2'h1;
  localparam logic [1:0] SEL_C = 2'h2;
  localparam logic [1:0] SLOT_0 = 2'h0;
  localparam logic [1:0] SLOT_1 = 2'h1;
  localparam logic [1:0] SLOT_2 = 2'h2;

  // ----------------------------------------------------------------------
  // field layout and writable masks (reserved bits read zero)
  // ----------------------------------------------------------------------
  localparam int PAY_LSB = 3;
  localparam int PAY_MSB = 8;
  localparam int HDR_LSB = 9;
  localparam int HDR_MSB = 15;
  localparam int PTH_LSB = 16;
  localparam int PTH_MSB = 17;
  localparam int HTH_LSB = 18;
  localparam int HTH_MSB = 19;
  localparam int WGT_LSB = 20;
  localparam int WGT_MSB = 22;
  localparam logic [31:0] MASK_P = 32'h007F_FFF8;
  localparam logic [31:0] MASK_NP = 32'h007F_FE00;
  localparam logic [31:0] MASK_C = 32'h007F_FFF8;

  // ----------------------------------------------------------------------
  // reset defaults by strapped width (payload in units of eight)
  // ----------------------------------------------------------------------
  localparam logic [5:0] PD_UP_X4 = 6'h10;
  localparam logic [5:0] PD_UP_X8 = 6'h10;
  localparam logic [5:0] PD_DN_X4 = 6'h10;
  localparam logic [5:0] PD_DN_X8 = 6'h12;
  localparam logic [6:0] PH_UP_X4 = 7'h10;
  localparam logic [6:0] PH_UP_X8 = 7'h20;
  localparam logic [6:0] PH_DN_X4 = 7'h19;
  localparam logic [6:0] PH_DN_X8 = 7'h2E;
  localparam logic [6:0] NPH_UP_X4 = 7'h0C;
  localparam logic [6:0] NPH_UP_X8 = 7'h16;
  localparam logic [6:0] NPH_DN_X4 = 7'h10;
  localparam logic [6:0] NPH_DN_X8 = 7'h1D;
  localparam logic [6:0] CPLH_UP_X4 = 7'h12;
  localparam logic [6:0] CPLH_UP_X8 = 7'h20;
  localparam logic [6:0] CPLH_DN_X4 = 7'h0C;
  localparam logic [6:0] CPLH_DN_X8 = 7'h16;

  // ----------------------------------------------------------------------
  // threshold codes, weight codes, clamps, timing
  // ----------------------------------------------------------------------
  localparam logic [1:0] TH_75 = 2'h0;
  localparam logic [1:0] TH_50 = 2'h1;
  localparam logic [1:0] TH_25 = 2'h2;
  localparam logic [1:0] TH_100 = 2'h3;
  localparam logic [2:0] WGT_WIDTH = 3'h0;
  localparam logic [2:0] WGT_MUL2 = 3'h1;
  localparam logic [2:0] WGT_MUL4 = 3'h2;
  localparam logic [2:0] WGT_MUL8 = 3'h3;
  localparam logic [2:0] WGT_NONE = 3'h4;
  localparam logic [2:0] WGT_DIV2 = 3'h5;
  localparam logic [2:0] WGT_DIV4 = 3'h6;
  localparam logic [2:0] WGT_DIV8 = 3'h7;
  localparam logic [7:0] EFF_MIN = 8'h01;
  localparam logic [7:0] EFF_MAX = 8'h08;
  localparam logic [1:0] SYNC_CYCLES = 2'h2;

  typedef enum logic [3:0] {
    ST_SYNC = 4'b0001,
    ST_DEF = 4'b0010,
    ST_LOAD = 4'b0100,
    ST_RUN = 4'b1000
  } icr_state_t;

endpackage : icr_pkg

// >>> logic/icr_grp_if.sv
/*
  Interface between the bank controller and one credit register group.
  Assumes both ends run on the same core clock.
*/
`timescale 1ns/1ps
interface icr_grp_if;
  logic load_def;
  logic def_x8;
  logic def_up;
  logic wr_en;
  logic [1:0] wr_sel;
  logic [31:0] wdata;
  logic [3:0] be;
  logic [31:0] p_word;
  logic [31:0] np_word;
  logic [31:0] c_word;

  modport grp (input load_def, def_x8, def_up, wr_en, wr_sel, wdata, be,
               output p_word, np_word, c_word);
  modport ctl (output load_def, def_x8, def_up, wr_en, wr_sel, wdata, be,
               input p_word, np_word, c_word);
endinterface : icr_grp_if

// >>> logic/icr_group.sv
/*
  One port's posted, non-posted and completion credit words.
  Assumes the controller asserts load_def for one cycle with the strapped
  width before any write reaches the group.
*/
`timescale 1ns/1ps
module icr_group #(
  parameter bit ZERO_DEF = 1'b0
) (
  input wire logic clk,
  input wire logic nrst,
  icr_grp_if.grp g
);

  logic [31:0] p_q;
  logic [31:0] np_q;
  logic [31:0] c_q;
  logic [31:0] def_p;
  logic [31:0] def_np;
  logic [31:0] def_c;

  // byte-lane merge; reserved bits never take a one
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be, input logic [31:0] mask);
    logic [31:0] lanes;
    lanes = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    return ((wd & lanes) | (old & ~lanes)) & mask;
  endfunction : merge

  // width/role dependent defaults; the internal port stays at zero
  always_comb begin
    def_p = '0;
    def_np = '0;
    def_c = '0;
    if (!ZERO_DEF) begin
      def_p[icr_pkg::PAY_MSB:icr_pkg::PAY_LSB] = g.def_up ?
        (g.def_x8 ? icr_pkg::PD_UP_X8 : icr_pkg::PD_UP_X4) :
        (g.def_x8 ? icr_pkg::PD_DN_X8 : icr_pkg::PD_DN_X4);
      def_p[icr_pkg::HDR_MSB:icr_pkg::HDR_LSB] = g.def_up ?
        (g.def_x8 ? icr_pkg::PH_UP_X8 : icr_pkg::PH_UP_X4) :
        (g.def_x8 ? icr_pkg::PH_DN_X8 : icr_pkg::PH_DN_X4);
      def_np[icr_pkg::HDR_MSB:icr_pkg::HDR_LSB] = g.def_up ?
        (g.def_x8 ? icr_pkg::NPH_UP_X8 : icr_pkg::NPH_UP_X4) :
        (g.def_x8 ? icr_pkg::NPH_DN_X8 : icr_pkg::NPH_DN_X4);
      def_c[icr_pkg::PAY_MSB:icr_pkg::PAY_LSB] = g.def_up ?
        (g.def_x8 ? icr_pkg::PD_UP_X8 : icr_pkg::PD_UP_X4) :
        (g.def_x8 ? icr_pkg::PD_DN_X8 : icr_pkg::PD_DN_X4);
      def_c[icr_pkg::HDR_MSB:icr_pkg::HDR_LSB] = g.def_up ?
        (g.def_x8 ? icr_pkg::CPLH_UP_X8 : icr_pkg::CPLH_UP_X4) :
        (g.def_x8 ? icr_pkg::CPLH_DN_X8 : icr_pkg::CPLH_DN_X4);
    end
  end

  // posted word
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      p_q <= '0;
    end else if (g.load_def) begin
      p_q <= def_p;
    end else if (g.wr_en && g.wr_sel == icr_pkg::SEL_P) begin
      p_q <= merge(p_q, g.wdata, g.be, icr_pkg::MASK_P);
    end
  end

  // non-posted word; payload bits are reserved since data sits with header
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      np_q <= '0;
    end else if (g.load_def) begin
      np_q <= def_np;
    end else if (g.wr_en && g.wr_sel == icr_pkg::SEL_NP) begin
      np_q <= merge(np_q, g.wdata, g.be, icr_pkg::MASK_NP);
    end
  end

  // completion word
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      c_q <= '0;
    end else if (g.load_def) begin
      c_q <= def_c;
    end else if (g.wr_en && g.wr_sel == icr_pkg::SEL_C) begin
      c_q <= merge(c_q, g.wdata, g.be, icr_pkg::MASK_C);
    end
  end

  assign g.p_word = p_q;
  assign g.np_word = np_q;
  assign g.c_word = c_q;

endmodule : icr_group

// >>> logic/icr_bank.sv
/*
  Ingress credit threshold register bank of a three-station switch:
  configuration and serial-memory access, strapped defaults, and the
  advertised VC0 credits, high-priority update thresholds and congested
  weighting per port.
  Assumes straps are pins (synchronised here); configuration, loader and
  negotiated link width come from logic on the same core clock.
*/
`timescale 1ns/1ps

module icr_bank #(
  parameter int NG = icr_pkg::NUM_GRP,
  parameter int CW = icr_pkg::CRED_W
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [NG-1:0] strap_x8,
  input wire logic [NG-1:0] strap_up,
  input wire logic ee_wr,
  input wire logic [1:0] ee_station,
  input wire logic [11:0] ee_offset,
  input wire logic [31:0] ee_wdata,
  input wire logic ee_done,
  output logic ee_ready,
  input wire logic cfg_req,
  input wire logic cfg_wr,
  input wire logic [1:0] cfg_station,
  input wire logic [11:0] cfg_offset,
  input wire logic [31:0] cfg_wdata,
  input wire logic [3:0] cfg_be,
  output logic cfg_ready,
  output logic cfg_ack_q,
  output logic cfg_miss_q,
  output logic [31:0] cfg_rdata_q,
  input wire logic [NG-1:0][3:0] link_width,
  output logic fc_init_valid,
  output logic [NG-1:0][CW-1:0] ph_cred_q,
  output logic [NG-1:0][CW-1:0] pd_cred_q,
  output logic [NG-1:0][CW-1:0] nph_cred_q,
  output logic [NG-1:0][CW-1:0] cplh_cred_q,
  output logic [NG-1:0][CW-1:0] cpld_cred_q,
  output logic [NG-1:0][CW-1:0] ph_hp_q,
  output logic [NG-1:0][CW-1:0] pd_hp_q,
  output logic [NG-1:0][CW-1:0] nph_hp_q,
  output logic [NG-1:0][CW-1:0] cplh_hp_q,
  output logic [NG-1:0][CW-1:0] cpld_hp_q,
  output logic [NG-1:0][3:0] eff_width_q,
  output logic [NG-1:0] pool_block_q
);

  // ----------------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------------

  // {hit, group[2:0], select[1:0]} for a station-relative offset
  function automatic logic [5:0] decode(input logic [1:0] st, input logic [11:0] off);
    logic [1:0] slot;
    logic [1:0] sel;
    logic hit;
    logic [2:0] grp;
    hit = 1'b1;
    slot = icr_pkg::SLOT_0;
    sel = icr_pkg::SEL_P;
    grp = '0;
    case (off)
      icr_pkg::OFF_POSTED_FIRST: begin slot = icr_pkg::SLOT_0; sel = icr_pkg::SEL_P; end
      icr_pkg::OFF_NONPOSTED_FIRST: begin slot = icr_pkg::SLOT_0; sel = icr_pkg::SEL_NP; end
      icr_pkg::OFF_COMPLETION_FIRST: begin slot = icr_pkg::SLOT_0; sel = icr_pkg::SEL_C; end
      icr_pkg::OFF_POSTED_SECOND: begin slot = icr_pkg::SLOT_1; sel = icr_pkg::SEL_P; end
      icr_pkg::OFF_NONPOSTED_SECOND: begin slot = icr_pkg::SLOT_1; sel = icr_pkg::SEL_NP; end
      icr_pkg::OFF_COMPLETION_SECOND: begin slot = icr_pkg::SLOT_1; sel = icr_pkg::SEL_C; end
      icr_pkg::OFF_POSTED_SIXTH: begin slot = icr_pkg::SLOT_2; sel = icr_pkg::SEL_P; end
      icr_pkg::OFF_NONPOSTED_SIXTH: begin slot = icr_pkg::SLOT_2; sel = icr_pkg::SEL_NP; end
      icr_pkg::OFF_COMPLETION_SIXTH: begin slot = icr_pkg::SLOT_2; sel = icr_pkg::SEL_C; end
      default: hit = 1'b0;
    endcase
    // outer stations own two groups; only the middle one has a sixth slot
    case (st)
      icr_pkg::STN_0: begin
        grp = icr_pkg::STN_BASE_0 + {1'b0, slot};
        if (slot == icr_pkg::SLOT_2) hit = 1'b0;
      end
      icr_pkg::STN_1: begin
        grp = icr_pkg::STN_BASE_1 + {1'b0, slot};
      end
      icr_pkg::STN_2: begin
        grp = icr_pkg::STN_BASE_2 + {1'b0, slot};
        if (slot == icr_pkg::SLOT_2) hit = 1'b0;
      end
      default: hit = 1'b0;
    endcase
    return {hit, grp, sel};
  endfunction : decode

  // high-priority update threshold as a credit count, in quarters
  function automatic logic [CW-1:0] hp_count(input logic [CW-1:0] cred,
                                             input logic [1:0] code);
    logic [2:0] quarters;
    logic [CW+2:0] prod;
    case (code)
      icr_pkg::TH_75: quarters = 3'h3;
      icr_pkg::TH_50: quarters = 3'h2;
      icr_pkg::TH_25: quarters = 3'h1;
      icr_pkg::TH_100: quarters = 3'h4;
      default: quarters = 3'h3;
    endcase
    prod = {3'h0, cred} * {{CW{1'b0}}, quarters};
    return prod[CW+1:2];
  endfunction : hp_count

  // congested weighting applied to the negotiated width, then clamped
  function automatic logic [3:0] eff_width(input logic [2:0] code, input logic [3:0] lw);
    logic [7:0] w;
    w = {4'h0, lw};
    case (code)
      icr_pkg::WGT_WIDTH: w = {4'h0, lw};
      icr_pkg::WGT_MUL2: w = {3'h0, lw, 1'b0};
      icr_pkg::WGT_MUL4: w = {2'h0, lw, 2'h0};
      icr_pkg::WGT_MUL8: w = {1'h0, lw, 3'h0};
      icr_pkg::WGT_DIV2: w = {5'h0, lw[3:1]};
      icr_pkg::WGT_DIV4: w = {6'h0, lw[3:2]};
      icr_pkg::WGT_DIV8: w = {7'h0, lw[3]};
      default: w = {4'h0, lw};
    endcase
    if (w < icr_pkg::EFF_MIN) w = icr_pkg::EFF_MIN;
    if (w > icr_pkg::EFF_MAX) w = icr_pkg::EFF_MAX;
    return w[3:0];
  endfunction : eff_width

  // ----------------------------------------------------------------------
  // strap synchronisers and start-up sequence
  // ----------------------------------------------------------------------
  logic [NG-1:0] x8_meta_q;
  logic [NG-1:0] x8_sync_q;
  logic [NG-1:0] up_meta_q;
  logic [NG-1:0] up_sync_q;
  logic [1:0] sync_cnt_q;
  icr_pkg::icr_state_t state_q;
  icr_pkg::icr_state_t state_d;

  // straps are pins: two flops before anything looks at them
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      x8_meta_q <= '0;
      x8_sync_q <= '0;
      up_meta_q <= '0;
      up_sync_q <= '0;
    end else begin
      x8_meta_q <= strap_x8;
      x8_sync_q <= x8_meta_q;
      up_meta_q <= strap_up;
      up_sync_q <= up_meta_q;
    end
  end

  // wait for the synchroniser to fill before trusting the straps
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync_cnt_q <= '0;
    end else if (state_q == icr_pkg::ST_SYNC) begin
      sync_cnt_q <= sync_cnt_q + 2'h1;
    end
  end

  // sequence: defaults, then serial memory, then advertise
  always_comb begin
    state_d = state_q;
    case (state_q)
      icr_pkg::ST_SYNC: begin
        if (sync_cnt_q == icr_pkg::SYNC_CYCLES) state_d = icr_pkg::ST_DEF;
      end
      icr_pkg::ST_DEF: state_d = icr_pkg::ST_LOAD;
      icr_pkg::ST_LOAD: begin
        if (ee_done && !ee_wr) state_d = icr_pkg::ST_RUN;
      end
      icr_pkg::ST_RUN: state_d = icr_pkg::ST_RUN;
      default: state_d = icr_pkg::ST_SYNC;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= icr_pkg::ST_SYNC;
    end else begin
      state_q <= state_d;
    end
  end

  // credits are only advertised once defaults and loader values are in
  assign fc_init_valid = (state_q == icr_pkg::ST_RUN);
  assign ee_ready = (state_q == icr_pkg::ST_LOAD);
  assign cfg_ready = (state_q == icr_pkg::ST_RUN);

  // ----------------------------------------------------------------------
  // access path: loader during load, configuration afterwards
  // ----------------------------------------------------------------------
  logic cfg_take;
  logic ee_take;
  logic [5:0] cfg_dec;
  logic [5:0] ee_dec;
  logic wr_any;
  logic [2:0] wr_grp;
  logic [1:0] wr_sel;
  logic [31:0] wr_data;
  logic [3:0] wr_be;
  logic [31:0] p_word [NG];
  logic [31:0] np_word [NG];
  logic [31:0] c_word [NG];
  logic [31:0] rd_word;

  assign cfg_take = cfg_req && cfg_ready;
  assign ee_take = ee_wr && ee_ready;
  assign cfg_dec = decode(cfg_station, cfg_offset);
  assign ee_dec = decode(ee_station, ee_offset);

  // one writer at a time: the states keep the two sources apart
  always_comb begin
    wr_any = 1'b0;
    wr_grp = '0;
    wr_sel = '0;
    wr_data = '0;
    wr_be = '0;
    if (ee_take && ee_dec[5]) begin
      wr_any = 1'b1;
      wr_grp = ee_dec[4:2];
      wr_sel = ee_dec[1:0];
      wr_data = ee_wdata;
      wr_be = 4'hF;
    end else if (cfg_take && cfg_wr && cfg_dec[5]) begin
      wr_any = 1'b1;
      wr_grp = cfg_dec[4:2];
      wr_sel = cfg_dec[1:0];
      wr_data = cfg_wdata;
      wr_be = cfg_be;
    end
  end

  // read mux; unmapped offsets read as zero
  always_comb begin
    rd_word = '0;
    if (cfg_dec[5]) begin
      case (cfg_dec[1:0])
        icr_pkg::SEL_P: rd_word = p_word[cfg_dec[4:2]];
        icr_pkg::SEL_NP: rd_word = np_word[cfg_dec[4:2]];
        icr_pkg::SEL_C: rd_word = c_word[cfg_dec[4:2]];
        default: rd_word = '0;
      endcase
    end
  end

  // answer one cycle after the request is taken
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cfg_ack_q <= 1'b0;
      cfg_miss_q <= 1'b0;
      cfg_rdata_q <= '0;
    end else begin
      cfg_ack_q <= cfg_take;
      cfg_miss_q <= cfg_take && !cfg_dec[5];
      if (cfg_take) cfg_rdata_q <= cfg_wr ? 32'h0000_0000 : rd_word;
    end
  end

  // ----------------------------------------------------------------------
  // register groups and advertised values
  // ----------------------------------------------------------------------
  icr_grp_if gif [NG] ();

  for (genvar i = 0; i < NG; i++) begin : g_grp
    logic [31:0] pw;
    logic [31:0] nw;
    logic [31:0] cw;
    logic [CW-1:0] ph;
    logic [CW-1:0] pd;
    logic [CW-1:0] nph;
    logic [CW-1:0] cplh;
    logic [CW-1:0] cpld;

    assign gif[i].load_def = (state_q == icr_pkg::ST_DEF);
    assign gif[i].def_x8 = x8_sync_q[i];
    assign gif[i].def_up = up_sync_q[i];
    assign gif[i].wr_en = wr_any && (wr_grp == 3'(i));
    assign gif[i].wr_sel = wr_sel;
    assign gif[i].wdata = wr_data;
    assign gif[i].be = wr_be;

    // the internal port resets to zero so no buffer goes to it
    icr_group #(
      .ZERO_DEF(i == icr_pkg::GRP_INTERNAL)
    ) u_group (
      .clk(clk),
      .nrst(nrst),
      .g(gif[i])
    );

    assign pw = gif[i].p_word;
    assign nw = gif[i].np_word;
    assign cw = gif[i].c_word;
    assign p_word[i] = pw;
    assign np_word[i] = nw;
    assign c_word[i] = cw;

    // payload fields count eight credits per step, headers one
    assign pd = {1'b0, pw[icr_pkg::PAY_MSB:icr_pkg::PAY_LSB], 3'h0};
    assign ph = {3'h0, pw[icr_pkg::HDR_MSB:icr_pkg::HDR_LSB]};
    assign nph = {3'h0, nw[icr_pkg::HDR_MSB:icr_pkg::HDR_LSB]};
    assign cpld = {1'b0, cw[icr_pkg::PAY_MSB:icr_pkg::PAY_LSB], 3'h0};
    assign cplh = {3'h0, cw[icr_pkg::HDR_MSB:icr_pkg::HDR_LSB]};

    // registered so the link side sees steady values, one cycle late
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        ph_cred_q[i] <= '0;
        pd_cred_q[i] <= '0;
        nph_cred_q[i] <= '0;
        cplh_cred_q[i] <= '0;
        cpld_cred_q[i] <= '0;
      end else begin
        ph_cred_q[i] <= ph;
        pd_cred_q[i] <= pd;
        nph_cred_q[i] <= nph;
        cplh_cred_q[i] <= cplh;
        cpld_cred_q[i] <= cpld;
      end
    end

    // update thresholds; non-posted payload has none of its own
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        ph_hp_q[i] <= '0;
        pd_hp_q[i] <= '0;
        nph_hp_q[i] <= '0;
        cplh_hp_q[i] <= '0;
        cpld_hp_q[i] <= '0;
      end else begin
        pd_hp_q[i] <= hp_count(pd, pw[icr_pkg::PTH_MSB:icr_pkg::PTH_LSB]);
        ph_hp_q[i] <= hp_count(ph, pw[icr_pkg::HTH_MSB:icr_pkg::HTH_LSB]);
        nph_hp_q[i] <= hp_count(nph, nw[icr_pkg::HTH_MSB:icr_pkg::HTH_LSB]);
        cpld_hp_q[i] <= hp_count(cpld, cw[icr_pkg::PTH_MSB:icr_pkg::PTH_LSB]);
        cplh_hp_q[i] <= hp_count(cplh, cw[icr_pkg::HTH_MSB:icr_pkg::HTH_LSB]);
      end
    end

    // congested weighting, taken from the posted word only
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        eff_width_q[i] <= '0;
        pool_block_q[i] <= 1'b0;
      end else begin
        eff_width_q[i] <= eff_width(pw[icr_pkg::WGT_MSB:icr_pkg::WGT_LSB], link_width[i]);
        pool_block_q[i] <= (pw[icr_pkg::WGT_MSB:icr_pkg::WGT_LSB] == icr_pkg::WGT_NONE);
      end
    end
  end

endmodule : icr_bank

// >>> verif/icr_link_partner.sv
/* Link partner model: offers a trained width per port and records the
   first posted header credit advertised for port 0. Assumes the bank's core clock. */
`timescale 1ns/1ps
module icr_link_partner (
  input wire logic clk,
  input wire logic fc_init_valid,
  input wire logic [6:0][9:0] ph_cred_q,
  output logic [6:0][3:0] link_width,
  output logic [9:0] first_ph
);
  // all links at x4, so weights can clamp both low and high
  assign link_width = {7{4'h4}};
  // only credits seen with init valid count as advertised
  initial first_ph = 10'h3FF;
  always @(posedge clk) begin
    if (fc_init_valid && first_ph === 10'h3FF) first_ph <= ph_cred_q[0];
  end
endmodule : icr_link_partner

// >>> verif/icr_bank_asserts.sv
/* Checker of config answers, credit outputs and states; bound to icr_bank. */
`timescale 1ns/1ps
module icr_bank_asserts #(parameter int NG = 7, parameter int CW = 10) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic cfg_req,
  input wire logic cfg_ready,
  input wire logic cfg_ack_q,
  input wire logic cfg_miss_q,
  input wire logic ee_ready,
  input wire logic fc_init_valid,
  input wire logic [NG-1:0][CW-1:0] pd_cred_q,
  input wire logic [NG-1:0][3:0] eff_width_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // a request that the bank takes
  sequence s_take; cfg_req && cfg_ready; endsequence
  take_ack_a: assert property (s_take |=> cfg_ack_q) else $error("ack missing");
  idle_ack_a: assert property (!(cfg_req && cfg_ready) |=> !cfg_ack_q) else $error("stray ack");
  miss_ack_a: assert property (cfg_miss_q |-> cfg_ack_q) else $error("miss alone");
  pay_step_a: assert property (pd_cred_q[1][2:0] == 3'h0) else $error("payload step");
  eff_clamp_a: assert property (fc_init_valid && $past(fc_init_valid)
    |-> eff_width_q[0] inside {[4'h1:4'h8]}) else $error("width clamp");
  ready_excl_a: assert property (!(ee_ready && cfg_ready)) else $error("both ready");
  run_hold_a: assert property (fc_init_valid |=> fc_init_valid) else $error("run lost");
  ready_run_a: assert property (cfg_ready |-> fc_init_valid) else $error("early cfg");
endmodule : icr_bank_asserts
bind icr_bank icr_bank_asserts #(.NG(NG), .CW(CW)) u_icr_bank_asserts (.clk, .nrst, .cfg_req,
  .cfg_ready, .cfg_ack_q, .cfg_miss_q, .ee_ready, .fc_init_valid, .pd_cred_q, .eff_width_q);

// >>> verif/icr_bank_tb.sv
/* Bench of icr_bank through its loader and config ports.
   Assumes the link partner model and the bound checker. */
`timescale 1ns/1ps
module icr_bank_tb;
  logic clk = 1'b0, nrst = 1'b0, ew = 1'b0, ed = 1'b0, rq = 1'b0, wr = 1'b0;
  logic er, cr, fv, ack, miss, ms;
  logic [1:0] es = 2'h0, cs = 2'h0;
  logic [11:0] eo = 12'h0, co = 12'h0;
  logic [31:0] edat = 32'h0, cd = 32'h0, rdat, rd;
  logic [3:0] be = 4'h0, q;
  logic [6:0][3:0] lw, eff;
  logic [6:0][9:0] ph, pd, phh, pdh, nc, hc, dc, nh, hh, dh;
  logic [6:0] blk;
  logic [9:0] fph;
  int num_errors = 0, checked = 0;
  // 50 MHz core clock
  always #10 clk = ~clk;
  // straps: group 0 downstream x8, group 1 upstream x4, others downstream x4
  icr_bank u_icr_bank (.clk, .nrst, .strap_x8(7'h01), .strap_up(7'h02), .ee_wr(ew),
    .ee_station(es), .ee_offset(eo), .ee_wdata(edat), .ee_done(ed), .ee_ready(er),
    .cfg_req(rq), .cfg_wr(wr), .cfg_station(cs), .cfg_offset(co), .cfg_wdata(cd),
    .cfg_be(be), .cfg_ready(cr), .cfg_ack_q(ack), .cfg_miss_q(miss), .cfg_rdata_q(rdat),
    .link_width(lw), .fc_init_valid(fv), .ph_cred_q(ph), .pd_cred_q(pd), .nph_cred_q(nc),
    .cplh_cred_q(hc), .cpld_cred_q(dc), .ph_hp_q(phh), .pd_hp_q(pdh), .nph_hp_q(nh),
    .cplh_hp_q(hh), .cpld_hp_q(dh), .eff_width_q(eff), .pool_block_q(blk));
  icr_link_partner u_icr_link_partner (.clk, .fc_init_valid(fv), .ph_cred_q(ph),
    .link_width(lw), .first_ph(fph));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // one-cycle request; the answer stands in the cycle after the taking edge
  task automatic cfg(input logic [1:0] s, input logic [11:0] o, input logic w,
    input logic [31:0] d, input logic [3:0] b);
    @(negedge clk);
    {rq, wr, cs, co, cd, be} = {1'b1, w, s, o, d, b};
    @(negedge clk);
    rq = 1'b0;
    chk(ack, 1'b1);
    {rd, ms} = {rdat, miss};
  endtask : cfg
  task automatic rdk(input logic [1:0] s, input logic [11:0] o, input logic [31:0] e,
    input logic m);
    cfg(s, o, 1'b0, 32'h0, 4'hF);
    chk(rd, e);
    chk(ms, m);
  endtask : rdk
  task automatic print_verdict();
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict
  // main sequence; internal port words are never written
  initial begin
    repeat (10) @(negedge clk);
    nrst = 1'b1;
    for (int i = 0; i < 20 && er !== 1'b1; i++) @(negedge clk);
    {ew, es, eo, edat} = {1'b1, 2'h0, 12'hA18, 32'h0013_1420};
    @(negedge clk);
    ew = 1'b0;
    ed = 1'b1;
    for (int i = 0; i < 20 && cr !== 1'b1; i++) @(negedge clk);
    // the partner only records at the edge after init valid rises
    @(negedge clk);
    chk(fph, 10'h2E);
    chk({er, cr, fv}, 3'h3);
    chk({nc[0], hc[0], dc[0]}, {10'h1D, 10'h16, 10'h90});
    chk({nh[0], hh[0], dh[0]}, {10'h15, 10'h10, 10'h6C});
    rdk(2'h0, 12'hA00, 32'h5C90, 1'b0);
    rdk(2'h0, 12'hA04, 32'h3A00, 1'b0);
    rdk(2'h0, 12'hA08, 32'h2C90, 1'b0);
    rdk(2'h0, 12'hA18, 32'h0013_1420, 1'b0);
    rdk(2'h0, 12'hA20, 32'h2480, 1'b0);
    rdk(2'h1, 12'hA00, 32'h0, 1'b0);
    rdk(2'h1, 12'hA30, 32'h3280, 1'b0);
    rdk(2'h2, 12'hA04, 32'h2000, 1'b0);
    rdk(2'h0, 12'hA30, 32'h0, 1'b1);
    rdk(2'h3, 12'hA00, 32'h0, 1'b1);
    chk({pd[1], pdh[1], eff[1]}, {10'h20, 10'h20, 4'h8});
    chk({ph[1], phh[1]}, {10'h0A, 10'h07});
    cfg(2'h0, 12'hA04, 1'b1, 32'hFFFF_FFFF, 4'h3);
    rdk(2'h0, 12'hA04, 32'h0000_FE00, 1'b0);
    for (int k = 0; k < 8; k++) begin
      cfg(2'h2, 12'hA18, 1'b1, {9'h0, k[2:0], k[1:0], k[1:0], 16'h2080}, 4'hF);
      @(negedge clk);
      q = 4'(16'h4123 >> (4 * k[1:0]));
      chk({pdh[6], phh[6]}, {10'(32 * q), 10'(4 * q)});
      if (k != 4) chk(eff[6], 4'(32'h1120_8884 >> (4 * k)));
      chk(blk[6], k == 4);
    end
    // nonzero threshold codes on the non-posted and completion words
    cfg(2'h2, 12'hA1C, 1'b1, 32'h000C_2000, 4'hF);
    cfg(2'h2, 12'hA20, 1'b1, 32'h0009_2080, 4'hF);
    @(negedge clk);
    chk({nc[6], nh[6]}, {10'h10, 10'h10});
    chk({dh[6], hh[6], hc[6]}, {10'h40, 10'h04, 10'h10});
    print_verdict();
  end
  // hang guard, well past the fewer than one hundred cycles the tests need
  initial begin
    repeat (4000) @(posedge clk);
    num_errors++;
    print_verdict();
  end
endmodule : icr_bank_tb
